// File: dv/dbs_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbs_fetch_model (
  // clock
  input  wire logic        clk,
  // decoded instruction
  output logic             insn_valid,
  output logic [7:0]       insn_op,
  output logic             insn_annul,
  output logic             insn_uncond,
  output logic             insn_cond_true,
  output logic [29:0]      insn_disp,
  output logic [12:0]      signed_immediate_field,
  output logic [31:0]      ndly_target,
  // selects, fixed but for insn_disp22: r0 reads zero, so each sum is the immediate
  output logic             insn_disp22,
  output logic             insn_imm,
  output logic [4:0]       insn_rs1,
  output logic [4:0]       insn_rs2,
  output logic [4:0]       insn_rd
);
  // only branches carry the short displacement
  assign insn_disp22 = (insn_op == 8'h02);
  assign insn_imm = 1'b1;
  assign insn_rs1 = 5'h00;
  assign insn_rs2 = 5'h00;
  assign insn_rd = 5'h01;
  initial begin
    insn_valid = 1'b0;
    {insn_op, insn_annul, insn_uncond, insn_cond_true} = 11'h000;
    {insn_disp, signed_immediate_field, ndly_target} = 75'h0;
  end
  // held for both cycles, then scrambled so nothing stale looks valid
  task automatic issue(input logic [7:0] op, input logic [2:0] f, input logic [31:0] v);
    @(posedge clk);
    insn_valid <= 1'b1;
    {insn_op, insn_annul, insn_uncond, insn_cond_true} <= {op, f};
    {insn_disp, signed_immediate_field, ndly_target} <= {v[29:0], v[12:0], v};
    repeat (2) @(posedge clk);
    insn_valid <= 1'b0;
    {insn_op, insn_annul, insn_uncond, insn_cond_true} <= ~{op, f};
    {insn_disp, signed_immediate_field, ndly_target} <= ~{v[29:0], v[12:0], v};
  endtask
endmodule
`default_nettype wire

// File: dv/dbs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dbs_monitor (
  // clock, reset and bus
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // instruction and results
  input wire logic        insn_valid,
  input wire logic [7:0]  insn_op,
  input wire logic        insn_annul,
  input wire logic        insn_uncond,
  input wire logic        insn_cond_true,
  input wire logic        annul_slot,
  input wire logic        trap_overflow,
  input wire logic        trap_underflow
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // one instruction is two held cycles
  sequence s_exec(op);
    (insn_valid && insn_op == op) [*2];
  endsequence
  sequence s_br(an);
    (insn_valid && insn_op == 8'h02 && insn_annul == an) [*2];
  endsequence
  ////////////////////////////////////////////////////////////
  a_apb_ready: assert property (psel && !penable |=> pready) else $error("no pready");
  a_bad_addr: assert property (psel && penable && pready && paddr > 12'h018 |-> pslverr)
    else $error("no pslverr");
  // annul state moves at the execute edge and reaches annul_slot one edge later
  a_annul_set: assert property (
    s_br(1'b1) ##0 (!annul_slot && !(insn_cond_true && !insn_uncond)) |=> ##1 annul_slot)
    else $error("slot kept");
  a_annul_taken: assert property (
    s_br(1'b1) ##0 (insn_cond_true && !insn_uncond) |=> ##1 !annul_slot)
    else $error("slot lost");
  a_annul_clear: assert property (
    s_br(1'b0) |=> ##1 !annul_slot) else $error("a0 annul");
  a_call_slot: assert property (
    s_exec(8'h04) |=> ##1 !annul_slot) else $error("call annul");
  a_ovf_cause: assert property (
    trap_overflow |-> $past(insn_valid) && $past(insn_op) == 8'h10) else $error("bad ovf");
  a_unf_cause: assert property (
    trap_underflow |-> $past(insn_valid) && $past(insn_op) == 8'h20) else $error("bad unf");
  a_trap_pulse: assert property (
    trap_overflow || trap_underflow |=> !trap_overflow && !trap_underflow) else $error("trap");
endmodule
bind dbs_sequencer dbs_monitor u_mon (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .insn_valid(insn_valid),
  .insn_op(insn_op), .insn_annul(insn_annul), .insn_uncond(insn_uncond),
  .insn_cond_true(insn_cond_true), .annul_slot(annul_slot), .trap_overflow(trap_overflow),
  .trap_underflow(trap_underflow));
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbs_defs.svh"
module tb_top;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, fetch_req, annul_slot;
  logic        insn_valid, insn_annul, insn_uncond, insn_cond_true, insn_disp22, insn_imm;
  logic        trap_overflow, trap_underflow, err_q;
  logic [2:0]  ec;
  logic [4:0]  insn_rs1, insn_rs2, insn_rd;
  logic [7:0]  insn_op;
  logic [11:0] paddr;
  logic [12:0] signed_immediate_field;
  logic [29:0] insn_disp;
  logic [31:0] pwdata, prdata, fetch_addr, ndly_target, rd_q, ep, en, el;
  int          num_errors, n_compared;
  dbs_sequencer dut (.*);
  dbs_fetch_model fm (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // wait on pready, bounded; no fixed wait-state count assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      num_errors++;
      stop_test();
    end
    {rd_q, err_q} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask
  task automatic pcs(input logic [31:0] p, input logic [31:0] n);
    rchk(`DBS_OFF_PC, p);
    rchk(`DBS_OFF_NPC, n);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    pcs(32'h0, 32'h4);
    rchk(`DBS_OFF_STATUS, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    chk({31'h0, fetch_req}, 32'h0);
    apb(1'b1, `DBS_OFF_CTRL, 32'h1);
    // run lands at the access edge, fetch_req one edge after it
    repeat (2) @(posedge clk);
    chk({31'h0, fetch_req}, 32'h1);
  endtask
  task automatic t_transfers;
    fm.issue(8'h01, 3'h0, 32'h0);
    pcs(32'h4, 32'h8);
    fm.issue(8'h04, 3'h0, 32'h10);
    pcs(32'h8, 32'h44);
    rchk(`DBS_OFF_LINK, 32'h4);
    fm.issue(8'h08, 3'h0, 32'h100);
    pcs(32'h44, 32'h100);
    rchk(`DBS_OFF_LINK, 32'h8);
    fm.issue(8'h01, 3'h0, 32'h0);
    fm.issue(8'h02, 3'h5, 32'h3ffffffc);
    rchk(`DBS_OFF_STATUS, 32'h0);
    fm.issue(8'h01, 3'h0, 32'h0);
    pcs(32'hf0, 32'hf4);
  endtask
  // every annul, family and outcome combination, a save in the slot
  task automatic t_annul;
    logic an;
    {ep, en, el, ec} = {32'hf0, 32'hf4, 32'h8, 3'h0};
    for (int i = 0; i < 8; i++) begin
      an = i[2] && !(i[0] && !i[1]);
      fm.issue(8'h02, i[2:0], 32'h4);
      {ep, en} = {en, i[0] ? ep + 32'h10 : en + 32'h4};
      rchk(`DBS_OFF_STATUS, {29'h0, an, 2'h0});
      chk({31'h0, annul_slot}, {31'h0, an});
      fm.issue(8'h10, 3'h0, i + 1);
      if (!an) begin
        el = i + 1;
        ec = ec - 3'h1;
      end
      {ep, en} = {en, en + 32'h4};
      rchk(`DBS_OFF_LINK, el);
      rchk(`DBS_OFF_CWP, {29'h0, ec});
      pcs(ep, en);
    end
  endtask
  task automatic t_window;
    fm.issue(8'h40, 3'h0, 32'h200);
    pcs(32'h200, 32'h204);
    chk(fetch_addr, 32'h200);
    fm.issue(8'h20, 3'h0, 32'h16);
    ec = ec + 3'h1;
    rchk(`DBS_OFF_CWP, {29'h0, ec});
    rchk(`DBS_OFF_LINK, 32'h16);
    apb(1'b1, `DBS_OFF_WIM, {24'h0, 8'h1 << (ec - 3'h1)});
    fm.issue(8'h10, 3'h0, 32'h5);
    rchk(`DBS_OFF_STATUS, 32'h1);
    rchk(`DBS_OFF_LINK, 32'h16);
    apb(1'b1, `DBS_OFF_WIM, {24'h0, 8'h1 << (ec + 3'h1)});
    fm.issue(8'h20, 3'h0, 32'h7);
    rchk(`DBS_OFF_STATUS, 32'h3);
    rchk(`DBS_OFF_CWP, {29'h0, ec});
    // sticky flags clear on a write of ones
    apb(1'b1, `DBS_OFF_STATUS, 32'h3);
    rchk(`DBS_OFF_STATUS, 32'h0);
  endtask
  initial begin
    {num_errors, n_compared} = 64'h0;
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_transfers();
    t_annul();
    t_window();
    stop_test();
  end
endmodule
`default_nettype wire

// File: verilog/dbs_defs.svh
`ifndef DBS_DEFS_SVH
`define DBS_DEFS_SVH

// apb register offsets (byte addresses)
`define DBS_OFF_CTRL     12'h000
`define DBS_OFF_WIM      12'h004
`define DBS_OFF_CWP      12'h008
`define DBS_OFF_PC       12'h00c
`define DBS_OFF_NPC      12'h010
`define DBS_OFF_STATUS   12'h014
`define DBS_OFF_LINK     12'h018

// ctrl fields
`define DBS_CTRL_RUN     0
// status fields
`define DBS_ST_OVF       0
`define DBS_ST_UNF       1
`define DBS_ST_ANNUL     2

// reset values and fixed constants
`define DBS_RST_PC       32'h0000_0000
`define DBS_RST_WIM      32'h0000_0000
`define DBS_INSN_BYTES   32'h0000_0004
`define DBS_CALL_LINK_RD 5'h0f

`endif

// File: verilog/dbs_pkg.sv
package dbs_pkg;
  // instruction class presented by the decoder
  typedef enum logic [7:0] {
    DBS_OP_PLAIN   = 8'h01,
    DBS_OP_BRANCH  = 8'h02,
    DBS_OP_CALL    = 8'h04,
    DBS_OP_JUMP_AND_LINK    = 8'h08,
    DBS_OP_SAVE    = 8'h10,
    DBS_OP_RESTORE = 8'h20,
    DBS_OP_NDLY    = 8'h40,
    DBS_OP_NONE    = 8'h80
  } dbs_op_t;

  typedef enum logic [1:0] {
    DBS_ST_IDLE = 2'b01,
    DBS_ST_RUN  = 2'b10
  } dbs_state_t;
endpackage

// File: verilog/dbs_sequencer.sv
// Operation
// - non-delayed transfer: target fetched next, no delay instruction between
// - delay instruction is at next program counter, normally pc plus 4
// - transfer in delay slot uses prior target as its delay address
// - taken delayed transfer runs delay then target; untaken runs on sequentially
// - annul bit clear: delay instruction always runs
// - annul bit set: delay runs only for taken conditional branch
// - annulled delay instruction changes nothing but the program counters
// - only conditional branch families have annul; others always run delay
// - branch-always and branch-never with annul set suppress the delay
// - call writes own address into register 15, pc-relative delayed transfer
// - jump-and-link writes own address into rd, delayed transfer to target
// - save adds in old window, decrements window pointer, writes new window
// - restore adds in old window, increments window pointer, writes new window
// - new window pointer checked against invalid mask: overflow or underflow
// - pc-relative target: sign-extend displacement, shift left two, add pc
// - indirect target: rs1 plus rs2, or rs1 plus sign-extended immediate
`timescale 1ns/1ps
`default_nettype none
`include "dbs_defs.svh"
module dbs_sequencer #(
  parameter int NWIN = 8
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic      [31:0]            prdata,
  output logic                        pslverr,
  // decoded instruction from fetch
  input  wire logic                   insn_valid,
  input  wire logic [7:0]             insn_op,
  input  wire logic                   insn_annul,
  input  wire logic                   insn_uncond,
  input  wire logic                   insn_cond_true,
  input  wire logic [29:0]            insn_disp,
  input  wire logic                   insn_disp22,
  input  wire logic                   insn_imm,
  input  wire logic [12:0]            signed_immediate_field,
  input  wire logic [4:0]             insn_rs1,
  input  wire logic [4:0]             insn_rs2,
  input  wire logic [4:0]             insn_rd,
  input  wire logic [31:0]            ndly_target,
  // fetch side
  output logic                        fetch_req,
  output logic      [31:0]            fetch_addr,
  output logic                        annul_slot,
  // traps
  output logic                        trap_overflow,
  output logic                        trap_underflow
);
  localparam int WW = $clog2(NWIN);

  ////////////////////////////////////////////////////////////////////////
  // state
  dbs_pkg::dbs_state_t state_reg;
  logic [31:0]         pc_reg;
  logic [31:0]         next_program_counter;
  logic [WW-1:0]       current_window_pointer;
  logic [31:0]         window_invalid_mask_reg;
  logic                run_reg;
  logic                annul_reg;
  logic [31:0]         link_reg;
  logic                ovf_reg;
  logic                unf_reg;

  // two-phase operand fetch: window file read data is registered
  logic                phase_reg;
  logic [31:0]         rs1_val;
  logic [31:0]         rs2_val;

  function automatic logic [WW+4:0] win_addr(input logic [WW-1:0] w, input logic [4:0] r);
    // globals live past the last window so no window slot is shared with them
    // ins of w alias outs of w+1, locals are private to w
    logic [WW-1:0] wn;
    wn = w + WW'(1);
    if (r < 5'd8) begin
      win_addr = {1'b1, {WW{1'b0}}, 1'b0, r[2:0]};
    end else if (r >= 5'd24) begin
      win_addr = {1'b0, wn, 1'b1, r[2:0]};
    end else if (r >= 5'd16) begin
      win_addr = {1'b0, w, 1'b0, r[2:0]};
    end else begin
      win_addr = {1'b0, w, 1'b1, r[2:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decoded control
  dbs_pkg::dbs_op_t op;
  logic             go;
  logic [31:0]      rel_target;
  logic [31:0]      ind_target;
  logic [31:0]      sum;
  logic [WW-1:0]    new_cwp;
  logic             win_trap;
  logic             is_branch;
  logic             taken;
  logic             kill_delay;
  logic             wr_en;
  logic [WW+4:0]    wr_addr;
  logic [31:0]      wr_data;
  logic [31:0]      rs1_op;
  logic [31:0]      rs2_op;
  logic             ovf_set;
  logic             unf_set;
  logic             ovf_clr;
  logic             unf_clr;

  always_comb begin
    op = dbs_pkg::dbs_op_t'(insn_op);
    go = run_reg && insn_valid && phase_reg && !annul_reg;
    is_branch = (op == dbs_pkg::DBS_OP_BRANCH);
    taken = insn_uncond ? insn_cond_true : insn_cond_true;
    // branch displacement is 22 bits, call is 30
    rel_target = pc_reg + (insn_disp22 ? {{8{insn_disp[21]}}, insn_disp[21:0], 2'b00}
                                       : {insn_disp, 2'b00});
    // r0 reads as zero whatever the store holds in that slot
    rs1_op = (insn_rs1 == 5'd0) ? 32'h0000_0000 : rs1_val;
    rs2_op = (insn_rs2 == 5'd0) ? 32'h0000_0000 : rs2_val;
    sum = rs1_op + (insn_imm ? {{19{signed_immediate_field[12]}}, signed_immediate_field}
                             : rs2_op);
    ind_target = sum;
    // annul only for branches; always/never suppress delay when set
    kill_delay = is_branch && insn_annul && (insn_uncond || !taken);
    new_cwp = (op == dbs_pkg::DBS_OP_SAVE) ? current_window_pointer - WW'(1)
                                           : current_window_pointer + WW'(1);
    win_trap = ((op == dbs_pkg::DBS_OP_SAVE) || (op == dbs_pkg::DBS_OP_RESTORE))
               && window_invalid_mask_reg[new_cwp];
    ovf_set = go && win_trap && (op == dbs_pkg::DBS_OP_SAVE);
    unf_set = go && win_trap && (op == dbs_pkg::DBS_OP_RESTORE);
    // write one to clear the sticky flags, independent of what executes
    ovf_clr = psel && penable && pwrite && (paddr == `DBS_OFF_STATUS) && pwdata[`DBS_ST_OVF];
    unf_clr = psel && penable && pwrite && (paddr == `DBS_OFF_STATUS) && pwdata[`DBS_ST_UNF];
    wr_en = 1'b0;
    wr_addr = win_addr(current_window_pointer, insn_rd);
    wr_data = pc_reg;
    if (go) begin
      case (op)
        dbs_pkg::DBS_OP_CALL: begin
          wr_en = 1'b1;
          wr_addr = win_addr(current_window_pointer, `DBS_CALL_LINK_RD);
        end
        dbs_pkg::DBS_OP_JUMP_AND_LINK: begin
          wr_en = (insn_rd != 5'd0);
        end
        dbs_pkg::DBS_OP_SAVE, dbs_pkg::DBS_OP_RESTORE: begin
          wr_en = !win_trap && (insn_rd != 5'd0);
          wr_addr = win_addr(new_cwp, insn_rd);
          wr_data = sum;
        end
        default: begin
          wr_en = 1'b0;
        end
      endcase
    end
  end

  dbs_window_file #(.NWIN(NWIN)) u_wf (
    .clk       (clk),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .rd_addr_a (win_addr(current_window_pointer, insn_rs1)),
    .rd_addr_b (win_addr(current_window_pointer, insn_rs2)),
    .rd_data_a (rs1_val),
    .rd_data_b (rs2_val)
  );

  ////////////////////////////////////////////////////////////////////////
  // program counter sequencing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= 1'b0;
    end else if (run_reg && insn_valid) begin
      // first cycle reads operands, second executes
      phase_reg <= !phase_reg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_reg <= `DBS_RST_PC;
      next_program_counter <= `DBS_RST_PC + `DBS_INSN_BYTES;
      annul_reg <= 1'b0;
    end else if (run_reg && insn_valid && phase_reg) begin
      // delay slot is whatever npc holds, so couples chain naturally
      pc_reg <= next_program_counter;
      next_program_counter <= next_program_counter + `DBS_INSN_BYTES;
      annul_reg <= 1'b0;
      if (annul_reg) begin
        annul_reg <= 1'b0;
      end else begin
        case (op)
          dbs_pkg::DBS_OP_NDLY: begin
            pc_reg <= ndly_target;
            next_program_counter <= ndly_target + `DBS_INSN_BYTES;
          end
          dbs_pkg::DBS_OP_BRANCH: begin
            if (taken) begin
              next_program_counter <= rel_target;
            end
            annul_reg <= kill_delay;
          end
          dbs_pkg::DBS_OP_CALL: begin
            next_program_counter <= rel_target;
          end
          dbs_pkg::DBS_OP_JUMP_AND_LINK: begin
            next_program_counter <= ind_target;
          end
          default: begin
            annul_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      current_window_pointer <= '0;
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
      trap_overflow <= 1'b0;
      trap_underflow <= 1'b0;
      link_reg <= 32'h0000_0000;
    end else begin
      trap_overflow <= ovf_set;
      trap_underflow <= unf_set;
      // a trap in the same cycle as a clear keeps its flag set
      ovf_reg <= (ovf_reg && !ovf_clr) || ovf_set;
      unf_reg <= (unf_reg && !unf_clr) || unf_set;
      // a trapped save or restore leaves the pointer where it was
      if (go && !win_trap &&
          (op == dbs_pkg::DBS_OP_SAVE || op == dbs_pkg::DBS_OP_RESTORE)) begin
        current_window_pointer <= new_cwp;
      end
      if (wr_en) begin
        link_reg <= wr_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetch_req <= 1'b0;
      fetch_addr <= `DBS_RST_PC;
      annul_slot <= 1'b0;
      state_reg <= dbs_pkg::DBS_ST_IDLE;
    end else begin
      fetch_req <= run_reg;
      fetch_addr <= pc_reg;
      annul_slot <= annul_reg;
      state_reg <= run_reg ? dbs_pkg::DBS_ST_RUN : dbs_pkg::DBS_ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_reg <= 1'b0;
      window_invalid_mask_reg <= `DBS_RST_WIM;
    end else if (psel && penable && pwrite) begin
      case (paddr)
        `DBS_OFF_CTRL: run_reg <= pwdata[`DBS_CTRL_RUN];
        `DBS_OFF_WIM:  window_invalid_mask_reg <= pwdata;
        default:       run_reg <= run_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `DBS_OFF_CTRL:   prdata <= {31'h0, run_reg};
          `DBS_OFF_WIM:    prdata <= window_invalid_mask_reg;
          `DBS_OFF_CWP:    prdata <= 32'(current_window_pointer);
          `DBS_OFF_PC:     prdata <= pc_reg;
          `DBS_OFF_NPC:    prdata <= next_program_counter;
          `DBS_OFF_STATUS: prdata <= {29'h0, annul_reg, unf_reg, ovf_reg};
          `DBS_OFF_LINK:   prdata <= link_reg;
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/dbs_window_file.sv
`timescale 1ns/1ps
`default_nettype none
// windowed register store, registered read ports
module dbs_window_file #(
  parameter int NWIN = 8
) (
  // clock
  input  wire logic                          clk,
  // write port
  input  wire logic                          wr_en,
  input  wire logic [$clog2(NWIN)+4:0]       wr_addr,
  input  wire logic [31:0]                   wr_data,
  // read ports
  input  wire logic [$clog2(NWIN)+4:0]       rd_addr_a,
  input  wire logic [$clog2(NWIN)+4:0]       rd_addr_b,
  output logic      [31:0]                   rd_data_a,
  output logic      [31:0]                   rd_data_b
);
  // sixteen slots per window, then eight global slots past the last window
  logic [31:0] mem [0:(16 << $clog2(NWIN)) + 7];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_a <= mem[rd_addr_a];
    rd_data_b <= mem[rd_addr_b];
  end
endmodule
`default_nettype wire
